// *** shared/usc_regs.vh ***
// Register offsets, field positions, reset values and timing counts of the serial port
`ifndef USC_REGS_VH
`define USC_REGS_VH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define USC_OFF_CTRL      8'h98
`define USC_OFF_DATA      8'h99
`define USC_OFF_PWR       8'h87
`define USC_OFF_BAUD      8'hbe

// ------------------------------------------------------------
// Control register fields
// ------------------------------------------------------------
`define USC_RX_EVT        0
`define USC_TX_EVT        1
`define USC_RX_NINTH      2
`define USC_TX_NINTH      3
`define USC_RX_EN         4
`define USC_MP_EN         5
`define USC_MODE_LO       6
`define USC_MODE_HI_ERR   7

// ------------------------------------------------------------
// Power/option register fields
// ------------------------------------------------------------
`define USC_RATE_DBL      7
`define USC_ERR_SEL       6
`define USC_TX_OPT        5

// ------------------------------------------------------------
// Modes, reset values and timing counts
// ------------------------------------------------------------
`define USC_MODE_SHIFT    2'b00
`define USC_MODE_8BIT     2'b01
`define USC_MODE_9FIX     2'b10
`define USC_MODE_9VAR     2'b11
`define USC_CTRL_RST      8'h00
`define USC_BAUD_RST      8'h00
`define USC_OVERSAMPLE    16
`define USC_M0_DIV        16
`define USC_M0_LAST       7'h7f

`endif

// *** rtl/usc_top.v ***
// Serial port control, mode, framing and shifting logic
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
`include "usc_regs.vh"

// What this block does
// - Rx flag: bit 8 end, mid-stop 8-bit
// - 9-bit: rx flag mid ninth or stop
// - Tx flag: bit 8 end, else stop
// - Hardware never clears event flags
// - Rx ninth bit: ninth bit or stop
// - Send tx ninth bit in 9-bit modes
// - Reception starts only while receive enable set
// - Multiproc: no 9-bit rx flag when ninth 0
// - Control bit 7: mode high or error
// - Bad stop sets sticky framing error
// - Code 00 shift mode, reset default
// - Shift mode: data on rx, clock tx
// - Frame: start, 8 data LSB, ninth if 9-bit, stop
// - Write starts tx; rx start conditions
// - Fixed 9-bit rate /32 or /16
module usc_top
(
    clk,
    rst_b,
    addr,
    wdata,
    wr,
    rd,
    rdata,
    rxd_in,
    rxd_out,
    rxd_oe,
    txd
);
    input  wire       clk;      // Core clock
    input  wire       rst_b;    // Async reset, active low
    input  wire [7:0] addr;     // Register address
    input  wire [7:0] wdata;    // Write data
    input  wire       wr;       // Write strobe
    input  wire       rd;       // Read strobe
    output reg  [7:0] rdata;    // Read data, cycle after rd
    input  wire       rxd_in;   // Receive pin level
    output reg        rxd_out;  // Receive pin drive value
    output reg        rxd_oe;   // Receive pin driven in shift-mode transmit
    output reg        txd;      // Transmit line or shift clock

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    reg        rxf_r;           // Receive event flag
    reg        txf_r;           // Transmit event flag
    reg        rx9_r;           // Received ninth bit
    reg        tx9_r;           // Ninth bit to send
    reg        ren_r;           // Receive enable
    reg        mp_r;            // Multiprocessor enable
    reg        mlo_r;           // Mode select low
    reg        mhi_r;           // Mode select high
    reg        ferr_r;          // Framing error flag
    reg        fsel_r;          // Framing error select
    reg        dbl_r;           // Rate double
    reg        topt_r;          // Tx event timing option
    reg  [7:0] baud_r;          // Variable rate divisor
    reg  [7:0] rbuf_r;          // Received character

    wire [1:0] mode = {mhi_r, mlo_r};
    wire       nine = mhi_r;    // Modes 10 and 11 carry a ninth bit
    wire       wr_ctrl = wr && (addr == `USC_OFF_CTRL);
    wire       wr_data = wr && (addr == `USC_OFF_DATA);

    // Hardware event requests, one cycle each
    reg        rxf_set;
    reg        txf_set;
    reg        ferr_set;
    reg        rx9_ld;
    reg        rx9_val;
    reg        rbuf_ld;
    reg  [7:0] rbuf_val;

    // ------------------------------------------------------------
    // Oversample tick generator
    // ------------------------------------------------------------
    reg  [7:0] div_r;           // Cycles until next tick
    reg  [7:0] div_lim;         // Reload value per mode
    wire       tick = (div_r == 8'h00);

    always @*
    begin
        if (mode == `USC_MODE_9FIX)
            div_lim = dbl_r ? 8'h00 : 8'h01;
        else
            div_lim = baud_r;
    end

    // Free-running divider; tick is sixteen per bit
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            div_r <= 8'h00;
        else if (tick)
            div_r <= div_lim;
        else
            div_r <= div_r - 8'h01;
    end

    // ------------------------------------------------------------
    // Shift-register mode engine
    // ------------------------------------------------------------
    reg        m0_busy_r;       // Engine running
    reg        m0_tx_r;         // Running a transmit
    reg  [6:0] m0_cnt_r;        // Phase within eight bits
    reg  [7:0] m0_sh_r;         // Shared shifter
    wire       m0_start_rx = (mode == `USC_MODE_SHIFT) && !m0_busy_r && !rxf_r && ren_r && !wr_data;

    // One bit per sixteen cycles; clock low first half
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            m0_busy_r <= 1'b0;
            m0_tx_r   <= 1'b0;
            m0_cnt_r  <= 7'h00;
            m0_sh_r   <= 8'h00;
        end
        else if (wr_data && (mode == `USC_MODE_SHIFT) && !m0_busy_r)
        begin
            m0_busy_r <= 1'b1;
            m0_tx_r   <= 1'b1;
            m0_cnt_r  <= 7'h00;
            m0_sh_r   <= wdata;
        end
        else if (m0_start_rx)
        begin
            m0_busy_r <= 1'b1;
            m0_tx_r   <= 1'b0;
            m0_cnt_r  <= 7'h00;
        end
        else if (m0_busy_r)
        begin
            m0_cnt_r <= m0_cnt_r + 7'h01;
            // LSB first, sample at rising shift clock
            if (m0_cnt_r[3:0] == 4'h8 && !m0_tx_r)
                m0_sh_r <= {rxd_in, m0_sh_r[7:1]};
            else if (m0_cnt_r[3:0] == 4'hf && m0_tx_r)
                m0_sh_r <= {1'b0, m0_sh_r[7:1]};
            if (m0_cnt_r == `USC_M0_LAST)
                m0_busy_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Asynchronous transmitter
    // ------------------------------------------------------------
    reg        tx_busy_r;       // Frame in progress
    reg [10:0] tx_sh_r;         // Frame bits, LSB out first
    reg  [3:0] tx_left_r;       // Bits still to send
    reg  [3:0] tx_tk_r;         // Ticks within bit

    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            tx_busy_r <= 1'b0;
            tx_sh_r   <= 11'h7ff;
            tx_left_r <= 4'h0;
            tx_tk_r   <= 4'h0;
        end
        else if (wr_data && (mode != `USC_MODE_SHIFT) && !tx_busy_r)
        begin
            tx_busy_r <= 1'b1;
            tx_sh_r   <= nine ? {1'b1, tx9_r, wdata, 1'b0} : {2'b11, wdata, 1'b0};
            tx_left_r <= nine ? 4'hb : 4'ha;
            tx_tk_r   <= 4'h0;
        end
        else if (tx_busy_r && tick)
        begin
            tx_tk_r <= tx_tk_r + 4'h1;
            if (tx_tk_r == 4'hf)
            begin
                tx_sh_r   <= {1'b1, tx_sh_r[10:1]};
                tx_left_r <= tx_left_r - 4'h1;
                if (tx_left_r == 4'h1)
                    tx_busy_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Asynchronous receiver
    // ------------------------------------------------------------
    reg  [1:0] rx_st_r;         // Idle, start, data, stop
    reg  [3:0] rx_tk_r;         // Ticks within bit
    reg  [3:0] rx_n_r;          // Data bits taken
    reg  [8:0] rx_sh_r;         // Data plus ninth bit
    localparam RX_IDLE  = 2'd0;
    localparam RX_START = 2'd1;
    localparam RX_DATA  = 2'd2;
    localparam RX_STOP  = 2'd3;
    wire [3:0] rx_nbits = nine ? 4'h9 : 4'h8;
    wire [8:0] rx_word  = nine ? {rxd_in, rx_sh_r[8:1]} : {1'b0, rxd_in, rx_sh_r[8:2]};

    // Mid-bit sampling, sixteen ticks apart
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rx_st_r <= RX_IDLE;
            rx_tk_r <= 4'h0;
            rx_n_r  <= 4'h0;
            rx_sh_r <= 9'h000;
        end
        else
        begin
            case (rx_st_r)
                RX_IDLE:
                    if (ren_r && (mode != `USC_MODE_SHIFT) && !rxd_in)
                    begin
                        rx_st_r <= RX_START;
                        rx_tk_r <= 4'h0;
                    end
                RX_START:
                    if (tick)
                    begin
                        rx_tk_r <= rx_tk_r + 4'h1;
                        if (rx_tk_r == 4'h7)
                        begin
                            rx_st_r <= rxd_in ? RX_IDLE : RX_DATA;
                            rx_tk_r <= 4'h0;
                            rx_n_r  <= 4'h0;
                        end
                    end
                RX_DATA:
                    if (tick)
                    begin
                        rx_tk_r <= rx_tk_r + 4'h1;
                        if (rx_tk_r == 4'hf)
                        begin
                            rx_sh_r <= {rxd_in, rx_sh_r[8:1]};
                            rx_n_r  <= rx_n_r + 4'h1;
                            if (rx_n_r == rx_nbits - 4'h1)
                                rx_st_r <= RX_STOP;
                        end
                    end
                default:
                    if (tick)
                    begin
                        rx_tk_r <= rx_tk_r + 4'h1;
                        if (rx_tk_r == 4'hf)
                            rx_st_r <= RX_IDLE;
                    end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Event decisions
    // ------------------------------------------------------------
    wire mid_last = (rx_st_r == RX_DATA) && tick && (rx_tk_r == 4'hf) && (rx_n_r == rx_nbits - 4'h1);
    wire mid_stop = (rx_st_r == RX_STOP) && tick && (rx_tk_r == 4'hf);

    always @*
    begin
        rxf_set  = 1'b0;
        txf_set  = 1'b0;
        ferr_set = 1'b0;
        rx9_ld   = 1'b0;
        rx9_val  = 1'b0;
        rbuf_ld  = 1'b0;
        rbuf_val = rx_word[7:0];
        if (m0_busy_r && (m0_cnt_r == `USC_M0_LAST))
        begin
            txf_set  = m0_tx_r;
            rxf_set  = !m0_tx_r;
            rbuf_ld  = !m0_tx_r;
            rbuf_val = m0_sh_r;
        end
        // stop start or end by option
        if (tx_busy_r && tick && (tx_tk_r == 4'hf) && (tx_left_r == (topt_r ? 4'h1 : 4'h2)))
            txf_set = 1'b1;
        if (nine && mid_last && !fsel_r)
        begin
            rx9_ld  = 1'b1;
            rx9_val = rxd_in;
            rbuf_ld = 1'b1;
            rxf_set = !(mp_r && !rxd_in);
        end
        if (mid_stop)
        begin
            ferr_set = !rxd_in;
            if (!nine)
            begin
                rx9_ld   = 1'b1;
                rx9_val  = rxd_in;
                rbuf_ld  = 1'b1;
                rbuf_val = rx_sh_r[8:1];
                rxf_set  = 1'b1;
            end
            else if (fsel_r)
            begin
                rx9_ld   = 1'b1;
                rx9_val  = rx_sh_r[8];
                rbuf_ld  = 1'b1;
                rbuf_val = rx_sh_r[7:0];
                rxf_set  = !(mp_r && !rx_sh_r[8]);
            end
        end
    end

    // ------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------
    // reset into shift mode
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            {mhi_r, mlo_r, mp_r, ren_r, tx9_r, rx9_r, txf_r, rxf_r} <= `USC_CTRL_RST;
            ferr_r <= 1'b0;
            fsel_r <= 1'b0;
            dbl_r  <= 1'b0;
            topt_r <= 1'b0;
            baud_r <= `USC_BAUD_RST;
            rbuf_r <= 8'h00;
        end
        else
        begin
            if (wr_ctrl)
            begin
                mlo_r <= wdata[`USC_MODE_LO];
                mp_r  <= wdata[`USC_MP_EN];
                ren_r <= wdata[`USC_RX_EN];
                tx9_r <= wdata[`USC_TX_NINTH];
                rx9_r <= wdata[`USC_RX_NINTH];
                txf_r <= wdata[`USC_TX_EVT];
                rxf_r <= wdata[`USC_RX_EVT];
                if (fsel_r)
                    ferr_r <= wdata[`USC_MODE_HI_ERR];
                else
                    mhi_r  <= wdata[`USC_MODE_HI_ERR];
            end
            if (wr && addr == `USC_OFF_PWR)
            begin
                dbl_r  <= wdata[`USC_RATE_DBL];
                fsel_r <= wdata[`USC_ERR_SEL];
                topt_r <= wdata[`USC_TX_OPT];
            end
            if (wr && addr == `USC_OFF_BAUD)
                baud_r <= wdata;
            if (rxf_set)
                rxf_r <= 1'b1;
            if (txf_set)
                txf_r <= 1'b1;
            if (ferr_set)
                ferr_r <= 1'b1;
            if (rx9_ld)
                rx9_r <= rx9_val;
            if (rbuf_ld)
                rbuf_r <= rbuf_val;
        end
    end

    // ------------------------------------------------------------
    // Read data and pins, all registered
    // ------------------------------------------------------------
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rdata   <= 8'h00;
            rxd_out <= 1'b1;
            rxd_oe  <= 1'b0;
            txd     <= 1'b1;
        end
        else
        begin
            if (rd && addr == `USC_OFF_CTRL)
                rdata <= {(fsel_r ? ferr_r : mhi_r), mlo_r, mp_r, ren_r, tx9_r, rx9_r, txf_r, rxf_r};
            else if (rd && addr == `USC_OFF_DATA)
                rdata <= rbuf_r;
            else if (rd && addr == `USC_OFF_PWR)
                rdata <= {dbl_r, fsel_r, topt_r, 5'h00};
            else if (rd && addr == `USC_OFF_BAUD)
                rdata <= baud_r;
            else
                rdata <= 8'h00;
            // shift clock on tx, data on rx
            if (mode == `USC_MODE_SHIFT)
            begin
                txd     <= m0_busy_r ? m0_cnt_r[3] : 1'b1;
                rxd_oe  <= m0_busy_r && m0_tx_r;
                rxd_out <= m0_busy_r ? m0_sh_r[0] : 1'b1;
            end
            else
            begin
                txd     <= tx_busy_r ? tx_sh_r[0] : 1'b1;
                rxd_oe  <= 1'b0;
                rxd_out <= 1'b1;
            end
        end
    end

endmodule // usc_top

// *** dv/usc_top_properties.sv ***
// Concurrent checks on the serial port control block pins
`timescale 1ns/1ps
`include "usc_regs.vh"

module usc_top_properties
(
    input wire       clk,
    input wire       rst_b,
    input wire [7:0] addr,
    input wire [7:0] wdata,
    input wire       wr,
    input wire       rd,
    input wire [7:0] rdata,
    input wire       rxd_in,
    input wire       rxd_out,
    input wire       rxd_oe,
    input wire       txd
);
    // ------------------------------------------------------------
    // Helper state mirrored from bus traffic and the txd pin
    // ------------------------------------------------------------
    reg  [1:0] mode_r;      // Mode as software last set it
    reg        err_sel_r;   // Bit 7 reads as framing error
    reg  [8:0] hi_cnt_r;    // Cycles txd has stayed high
    reg  [1:0] flag_seen_r; // Event flags known to be set
    reg        rd_ctrl_r;   // Control read answered now
    wire       ctrl_acc;    // Access aims at control
    wire       mapped;      // Address is decoded

    assign ctrl_acc = (addr == `USC_OFF_CTRL);
    assign mapped   = ctrl_acc || addr == `USC_OFF_DATA || addr == `USC_OFF_PWR || addr == `USC_OFF_BAUD;

    // Mode high only lands while bit 7 means mode
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            mode_r      <= 2'b00;
            err_sel_r   <= 1'b0;
            hi_cnt_r    <= 9'h000;
            flag_seen_r <= 2'b00;
            rd_ctrl_r   <= 1'b0;
        end
        else
        begin
            if (wr && addr == `USC_OFF_PWR)
                err_sel_r <= wdata[`USC_ERR_SEL];
            if (wr && ctrl_acc)
                mode_r <= {err_sel_r ? mode_r[1] : wdata[7], wdata[6]};
            // Saturate so a long idle never wraps
            hi_cnt_r  <= !txd ? 9'h000 : (hi_cnt_r == 9'h1ff ? hi_cnt_r : hi_cnt_r + 9'h001);
            rd_ctrl_r <= rd && ctrl_acc;
            // A write resets what software can still expect
            if (wr && ctrl_acc)
                flag_seen_r <= wdata[1:0];
            else if (rd_ctrl_r)
                flag_seen_r <= flag_seen_r | rdata[1:0];
        end
    end

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence s_low8;
        !txd [*8];
    endsequence
    sequence s_high8;
        txd [*8];
    endsequence

    property p_rdata_idle;
        !rd |=> rdata == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero outside answer");

    property p_unmapped;
        rd && !mapped |=> rdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

    property p_reset_out;
        $rose(rst_b) |-> txd && !rxd_oe && rdata == 8'h00;
    endproperty
    a_reset_out: assert property (p_reset_out) else $error("pins not idle after reset");

    property p_tx_start;
        wr && addr == `USC_OFF_DATA && mode_r == `USC_MODE_9FIX && hi_cnt_r >= 9'h190 |-> ##[1:40] !txd;
    endproperty
    a_tx_start: assert property (p_tx_start) else $error("data write did not start frame");

    property p_start_low;
        $fell(txd) |-> s_low8;
    endproperty
    a_start_low: assert property (p_start_low) else $error("txd low phase too short");

    property p_shift_clk;
        $rose(txd) && mode_r == `USC_MODE_SHIFT |-> s_high8;
    endproperty
    a_shift_clk: assert property (p_shift_clk) else $error("shift clock high phase too short");

    property p_oe_mode;
        rxd_oe |-> mode_r == `USC_MODE_SHIFT;
    endproperty
    a_oe_mode: assert property (p_oe_mode) else $error("receive pin driven outside shift mode");

    property p_flags_sticky;
        rd && ctrl_acc && flag_seen_r != 2'b00 |=> (rdata[1:0] & flag_seen_r) == flag_seen_r;
    endproperty
    a_flags_sticky: assert property (p_flags_sticky) else $error("event flag dropped by hardware");
endmodule // usc_top_properties

bind usc_top usc_top_properties i_usc_top_properties (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .rxd_in(rxd_in), .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd(txd));

// *** dv/usc_peer.sv ***
// Remote serial peer: sends and receives asynchronous frames
`timescale 1ns/1ps

module usc_peer
#(
    parameter BIT_CLKS = 16
)
(
    input wire clk,
    input wire txd,
    output reg rxd_drv
);
    // Line idles high between frames
    initial rxd_drv = 1'b1;

    // ------------------------------------------------------------
    // Frame sender
    // ------------------------------------------------------------
    // start low, data LSB first, ninth if nine_en, stop
    task send_frame(input [7:0] d, input nine_en, input b9, input stop);
        integer    i;
        reg [10:0] f;
    begin
        f = nine_en ? {stop, b9, d, 1'b0} : {1'b1, stop, d, 1'b0};
        @(posedge clk);
        for (i = 0; i < (nine_en ? 11 : 10); i = i + 1)
        begin
            rxd_drv <= f[i];
            repeat (BIT_CLKS) @(posedge clk);
        end
        rxd_drv <= 1'b1;
    end
    endtask

    // ------------------------------------------------------------
    // Frame receiver, samples each bit in its middle
    // ------------------------------------------------------------
    task recv_frame(input nine_en, output [7:0] d, output b9, output ok);
        integer   i;
        reg [9:0] s;
    begin
        s = 10'h000;
        @(negedge txd);
        repeat (BIT_CLKS / 2) @(posedge clk);
        #1 ok = !txd;
        for (i = 0; i < (nine_en ? 10 : 9); i = i + 1)
        begin
            repeat (BIT_CLKS) @(posedge clk);
            #1 s[i] = txd;
        end
        d  = s[7:0];
        b9 = nine_en ? s[8] : 1'b0;
        ok = ok && (nine_en ? s[9] : s[8]);
    end
    endtask
endmodule // usc_peer

// *** dv/usc_top_tb.sv ***
// Self-checking bench for the serial port control block
`timescale 1ns/1ps
`include "usc_regs.vh"

module usc_top_tb;
    reg         clk;
    reg         rst_b;
    reg  [7:0]  addr;
    reg  [7:0]  wdata;
    reg         wr;
    reg         rd;
    wire [7:0]  rdata;
    wire        rxd_out;
    wire        rxd_oe;
    wire        txd;
    wire        peer_drv;
    wire        rxd_pin;     // Resolved receive pin level
    integer     error_cnt;
    integer     n_compared;
    integer     k;
    reg  [7:0]  got;
    reg  [7:0]  pd;          // Byte seen by the peer
    reg         pb9;
    reg         pok;
    reg  [7:0]  sh_bits;     // Shift-mode bits seen on the pin
    // Receive cases: control value, ninth bit, expected control, mask
    reg  [31:0] rx_ctrl = 32'hf0_b0_90_80;
    reg  [3:0]  rx_nin  = 4'b1011;
    reg  [31:0] rx_exp  = 32'hf5_b0_95_80;
    reg  [31:0] rx_msk  = 32'hff_fb_ff_fb;

    // Device drives the pin only in shift-mode transmit
    assign rxd_pin = rxd_oe ? rxd_out : peer_drv;

    usc_top i_usc_top (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .rxd_in(rxd_pin), .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd(txd));
    usc_peer #(.BIT_CLKS(16)) i_usc_peer (.clk(clk), .txd(txd), .rxd_drv(peer_drv));

    // ------------------------------------------------------------
    // Clock, bus tasks and comparison
    // ------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task wr_reg(input [7:0] a, input [7:0] d);
    begin
        @(posedge clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    end
    endtask

    // Answer stands only in the cycle after the strobe
    task rd_chk(input [7:0] a, input [7:0] e, input [7:0] m);
    begin
        @(posedge clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 got = rdata;
        n_compared = n_compared + 1;
        if ((got & m) !== (e & m))
        begin
            error_cnt = error_cnt + 1;
            $display("wrong value at %0t: addr %h got %h expected %h", $time, a, got, e);
        end
    end
    endtask

    // Compare a value seen on the serial pins
    task pin_chk(input [7:0] g, input [7:0] e);
    begin
        n_compared = n_compared + 1;
        if (g !== e)
        begin
            error_cnt = error_cnt + 1;
            $display("wrong value at %0t: pin got %h expected %h", $time, g, e);
        end
    end
    endtask

    task close_out;
    begin
        $display("comparisons %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    end
    endtask

    // Run needs about 3000 cycles; generous margin
    initial
    begin
        repeat (20000) @(posedge clk);
        error_cnt = error_cnt + 1;
        close_out;
    end

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial
    begin
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
        rst_b = 1'b0;
        error_cnt = 0;
        n_compared = 0;
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        rd_chk(`USC_OFF_CTRL, `USC_CTRL_RST, 8'hff);
        rd_chk(8'h55, 8'h00, 8'hff);
        $display("test reset done");
        // Shift-mode transmit, bit sampled mid low phase
        fork
            wr_reg(`USC_OFF_DATA, 8'ha5);
            for (k = 0; k < 8; k = k + 1)
            begin
                @(negedge txd);
                repeat (4) @(posedge clk);
                #1 sh_bits[k] = rxd_pin;
            end
        join
        rd_chk(8'h55, 8'h00, 8'hff);
        repeat (20) @(posedge clk);
        rd_chk(`USC_OFF_CTRL, 8'h02, 8'hfb);
        repeat (50) @(posedge clk);
        rd_chk(`USC_OFF_CTRL, 8'h02, 8'hfb);
        pin_chk(sh_bits, 8'ha5);
        // Shift-mode receive starts on enable with flag clear
        wr_reg(`USC_OFF_CTRL, 8'h10);
        repeat (150) @(posedge clk);
        rd_chk(`USC_OFF_CTRL, 8'h11, 8'hfb);
        rd_chk(`USC_OFF_DATA, 8'hff, 8'hff);
        $display("test shift mode done");
        // Fixed 9-bit transmit at 16 clocks per bit, both ninth values
        wr_reg(`USC_OFF_PWR, 8'h80);
        for (k = 0; k < 2; k = k + 1)
        begin
            wr_reg(`USC_OFF_CTRL, {4'h8, k[0], 3'b000});
            repeat (420) @(posedge clk);
            fork
                i_usc_peer.recv_frame(1'b1, pd, pb9, pok);
                wr_reg(`USC_OFF_DATA, 8'h3c ^ k[7:0]);
            join
            repeat (40) @(posedge clk);
            rd_chk(`USC_OFF_CTRL, {4'h8, k[0], 3'b010}, 8'hfb);
            wr_reg(`USC_OFF_BAUD, pd);
            rd_chk(`USC_OFF_BAUD, 8'h3c ^ k[7:0], 8'hff);
            rd_chk(8'h55, 8'h00, 8'hff);
            pin_chk({6'h00, pok, pb9}, {7'h01, k[0]});
        end
        wr_reg(`USC_OFF_BAUD, 8'h00);
        $display("test 9-bit transmit done");
        // 9-bit receive: enable off, on, address filter, variable rate last
        for (k = 0; k < 4; k = k + 1)
        begin
            wr_reg(`USC_OFF_CTRL, rx_ctrl[8*k +: 8]);
            i_usc_peer.send_frame(8'h5a ^ k[7:0], 1'b1, rx_nin[k], 1'b1);
            repeat (20) @(posedge clk);
            rd_chk(`USC_OFF_CTRL, rx_exp[8*k +: 8], rx_msk[8*k +: 8]);
            if (rx_exp[8*k])
                rd_chk(`USC_OFF_DATA, 8'h5a ^ k[7:0], 8'hff);
        end
        // 8-bit receive, stop bit lands in ninth field
        wr_reg(`USC_OFF_CTRL, 8'h50);
        i_usc_peer.send_frame(8'hc3, 1'b0, 1'b0, 1'b1);
        repeat (20) @(posedge clk);
        rd_chk(`USC_OFF_CTRL, 8'h55, 8'hff);
        rd_chk(`USC_OFF_DATA, 8'hc3, 8'hff);
        $display("test receive done");
        // Framing error: sticky, cleared by write, bit 7 shared
        wr_reg(`USC_OFF_CTRL, 8'h90);
        wr_reg(`USC_OFF_PWR, 8'hc0);
        i_usc_peer.send_frame(8'h11, 1'b1, 1'b1, 1'b0);
        repeat (40) @(posedge clk);
        rd_chk(`USC_OFF_CTRL, 8'h90, 8'hf0);
        i_usc_peer.send_frame(8'h22, 1'b1, 1'b1, 1'b1);
        repeat (20) @(posedge clk);
        rd_chk(`USC_OFF_CTRL, 8'h90, 8'hf0);
        wr_reg(`USC_OFF_CTRL, 8'h10);
        rd_chk(`USC_OFF_CTRL, 8'h10, 8'hf0);
        wr_reg(`USC_OFF_PWR, 8'h80);
        rd_chk(`USC_OFF_CTRL, 8'h90, 8'hf0);
        $display("test framing error done");
        close_out;
    end
endmodule // usc_top_tb
